// ===== reset_source_controller.sv
module reset_source_controller #(
   parameter int ULP_DIV = reset_source_pkg::ULP_DIV_CYC
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [7:0] rd_data_out,
   // Configuration change protection window open
   input wire logic ccp_unlock_in,
   // Reset sources
   input wire logic supply_below_por_in,
   input wire logic bod_below_in,
   input wire logic pin_reset_n_in,
   input wire logic watchdog_timeout_in,
   input wire logic debug_reset_req_in,
   // Device conditions
   input wire logic debug_enabled_in,
   input wire logic chip_erase_in,
   input wire logic programming_mode_in,
   input wire logic deep_sleep_in,
   input wire reset_source_pkg::fuse_s fuses_in,
   // Results
   output logic device_reset_out,
   output logic cpu_halt_out,
   output logic bod_enable_out,
   output logic [2:0] bod_level_out
);
   import reset_source_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_HOLD,
      ST_ULP_WAIT,
      ST_SYS_WAIT,
      ST_RUN
   } seq_state_e;

   logic [16:0] ulp_div_ff, nxt_ulp_div; // ULTRA_LOW_POWER_OSCILLATOR tick divider
   logic [5:0] osc_div_ff, nxt_osc_div; // 2MHz tick divider
   logic ulp_tick; // One pulse per ULTRA_LOW_POWER_OSCILLATOR period
   logic osc_tick; // One pulse per 2MHz period
   logic [7:0] bod_cnt_ff, nxt_bod_cnt; // Brownout low time
   logic [7:0] ext_cnt_ff, nxt_ext_cnt; // Pin low time
   logic bod_rst_ff, nxt_bod_rst; // Brownout source
   logic ext_rst_ff, nxt_ext_rst; // Pin source
   logic [1:0] wdt_cnt_ff, nxt_wdt_cnt; // Watchdog stretch
   logic force_cont_ff, nxt_force_cont; // Sampled fell back
   logic bod_en_ff, nxt_bod_en; // Detector power
   logic [2:0] level_ff, nxt_level; // Latched threshold
   logic [2:0] out_level_ff, nxt_out_level; // Applied level
   logic [1:0] mode; // Decoded detector mode
   logic forced; // Erase or debug override
   logic continuous; // Detector monitoring all the time
   logic wdt_src;
   logic sw_src;
   logic any_src;
   seq_state_e state_ff, nxt_state;
   logic [16:0] seq_cnt_ff, nxt_seq_cnt; // Release countdown
   logic reset_ff, nxt_reset;
   logic [5:0] flags_ff, nxt_flags; // Cause flags
   logic soft_reset_request_ff, nxt_soft_reset_request; // Soft reset request
   logic [7:0] rd_data_ff, nxt_rd_data;

   // ----------------------------------------
   // Clock dividers
   // ----------------------------------------

   // Slow ticks for the ULTRA_LOW_POWER_OSCILLATOR and 2MHz time bases
   always_comb begin
      ulp_tick = (ulp_div_ff == 17'(ULP_DIV - 1));
      osc_tick = (osc_div_ff == 6'(OSC2M_DIV_CYC - 1));
      nxt_ulp_div = ulp_tick ? 17'h0 : ulp_div_ff + 17'h1;
      nxt_osc_div = osc_tick ? 6'h0 : osc_div_ff + 6'h1;
   end

   // Divider registers
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ulp_div_ff <= 17'h0;
         osc_div_ff <= 6'h0;
      end else begin
         ulp_div_ff <= nxt_ulp_div;
         osc_div_ff <= nxt_osc_div;
      end
   end

   // ----------------------------------------
   // Brownout detector control
   // ----------------------------------------

   // Mode select, override and threshold handling
   always_comb begin
      // Sleep fuse outside active and idle
      mode = deep_sleep_in ? fuses_in.brownout_sleep_mode_select
                           : fuses_in.brownout_active_mode_select;
      // Reserved code behaves as disabled
      if (mode == MODE_RESERVED) begin
         mode = MODE_DISABLED;
      end
      forced = (mode == MODE_DISABLED) &&
               (chip_erase_in || debug_enabled_in);
      continuous = (mode == MODE_ENABLED) || forced ||
                   ((mode == MODE_SAMPLED) && force_cont_ff);
      // Fuse value only loads outside programming mode
      nxt_level = programming_mode_in ? level_ff
                : ~fuses_in.brownout_threshold_select;
      nxt_out_level = forced ? LEVEL_LOWEST : level_ff;
      // Power the detector once per ULTRA_LOW_POWER_OSCILLATOR tick when sampling
      nxt_bod_en = continuous ||
                   ((mode == MODE_SAMPLED) && ulp_tick);
      nxt_force_cont = force_cont_ff;
      if ((mode == MODE_SAMPLED) && bod_en_ff && bod_below_in) begin
         nxt_force_cont = 1'b1;
      end else if (!bod_below_in && !bod_rst_ff) begin
         nxt_force_cont = 1'b0; // Supply back above
      end
      // Low time counted only while monitoring
      nxt_bod_cnt = 8'h0;
      if (continuous && bod_en_ff && bod_below_in) begin
         nxt_bod_cnt = (bod_cnt_ff == 8'(T_BOD_CYC)) ? bod_cnt_ff
                     : bod_cnt_ff + 8'h1;
      end
      // Valid once the dip outlasts the filter
      nxt_bod_rst = (nxt_bod_cnt == 8'(T_BOD_CYC)) ||
                    (bod_rst_ff && bod_below_in);
      if (mode == MODE_DISABLED && !forced) begin
         nxt_bod_rst = 1'b0; // No monitoring
      end
   end

   // Detector registers
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         level_ff <= LEVEL_LOWEST;
         out_level_ff <= LEVEL_LOWEST;
         bod_en_ff <= 1'b0;
         force_cont_ff <= 1'b0;
         bod_cnt_ff <= 8'h0;
         bod_rst_ff <= 1'b0;
      end else begin
         level_ff <= nxt_level;
         out_level_ff <= nxt_out_level;
         bod_en_ff <= nxt_bod_en;
         force_cont_ff <= nxt_force_cont;
         bod_cnt_ff <= nxt_bod_cnt;
         bod_rst_ff <= nxt_bod_rst;
      end
   end

   // ----------------------------------------
   // Pin and watchdog sources
   // ----------------------------------------

   // Pin filter and watchdog pulse stretch
   always_comb begin
      nxt_ext_cnt = 8'h0;
      if (!pin_reset_n_in) begin
         nxt_ext_cnt = (ext_cnt_ff == 8'(T_EXT_CYC)) ? ext_cnt_ff
                     : ext_cnt_ff + 8'h1;
      end
      // Held for as long as the pin stays low
      nxt_ext_rst = (nxt_ext_cnt == 8'(T_EXT_CYC));
      // Ends on the second 2MHz tick after the timeout
      nxt_wdt_cnt = wdt_cnt_ff;
      if (watchdog_timeout_in) begin
         nxt_wdt_cnt = 2'h2;
      end else if (osc_tick && wdt_cnt_ff != 2'h0) begin
         nxt_wdt_cnt = wdt_cnt_ff - 2'h1;
      end
   end

   // Pin and watchdog registers
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_cnt_ff <= 8'h0;
         ext_rst_ff <= 1'b0;
         wdt_cnt_ff <= 2'h0;
      end else begin
         ext_cnt_ff <= nxt_ext_cnt;
         ext_rst_ff <= nxt_ext_rst;
         wdt_cnt_ff <= nxt_wdt_cnt;
      end
   end

   // ----------------------------------------
   // Release sequencer
   // ----------------------------------------

   // Combine sources and time the release
   always_comb begin
      wdt_src = (wdt_cnt_ff != 2'h0);
      sw_src = soft_reset_request_ff;
      any_src = supply_below_por_in || bod_rst_ff || ext_rst_ff ||
                wdt_src || sw_src || debug_reset_req_in;
      nxt_state = state_ff;
      nxt_seq_cnt = seq_cnt_ff;
      if (any_src) begin
         // Any request restarts the whole sequence
         nxt_state = ST_HOLD;
         nxt_seq_cnt = 17'h0;
      end else begin
         unique case (state_ff)
            // All sources released: pick the delay
            ST_HOLD: begin
               if (fuses_in.startup_delay_code == DELAY_64K) begin
                  nxt_state = ST_ULP_WAIT;
                  nxt_seq_cnt = ULP_COUNT_64K;
               end else if (fuses_in.startup_delay_code == DELAY_4K) begin
                  nxt_state = ST_ULP_WAIT;
                  nxt_seq_cnt = ULP_COUNT_4K;
               end else begin
                  nxt_state = ST_SYS_WAIT;
                  nxt_seq_cnt = {12'h0, SYS_COUNT};
               end
            end
            // Count ULTRA_LOW_POWER_OSCILLATOR periods
            ST_ULP_WAIT: begin
               if (ulp_tick) begin
                  nxt_seq_cnt = seq_cnt_ff - 17'h1;
                  if (seq_cnt_ff == 17'h1) begin
                     nxt_state = ST_SYS_WAIT;
                     nxt_seq_cnt = {12'h0, SYS_COUNT};
                  end
               end
            end
            // Count system clocks at 2MHz
            ST_SYS_WAIT: begin
               if (osc_tick) begin
                  nxt_seq_cnt = seq_cnt_ff - 17'h1;
                  if (seq_cnt_ff == 17'h1) begin
                     nxt_state = ST_RUN;
                  end
               end
            end
            // Running
            ST_RUN: begin
               nxt_state = ST_RUN;
            end
         endcase
      end
      nxt_reset = (nxt_state != ST_RUN);
   end

   // Sequencer registers
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= ST_HOLD;
         seq_cnt_ff <= 17'h0;
         reset_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         seq_cnt_ff <= nxt_seq_cnt;
         reset_ff <= nxt_reset;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------

   // Flag set and clear, soft request, read data
   always_comb begin
      nxt_flags = flags_ff;
      // Write of one clears; reserved bits 7:6 ignored
      if (wr_en_in && addr_in == CAUSE_FLAGS_OFS) begin
         nxt_flags = flags_ff & ~wr_data_in[5:0];
      end
      // Power-on clears the other flags
      if (supply_below_por_in) begin
         nxt_flags = 6'h0;
      end
      // Sets win over clears
      nxt_flags[POWER_ON_BIT] = nxt_flags[POWER_ON_BIT] |
                                supply_below_por_in;
      nxt_flags[PIN_BIT] = nxt_flags[PIN_BIT] | ext_rst_ff;
      nxt_flags[BROWNOUT_BIT] = nxt_flags[BROWNOUT_BIT] |
                                bod_rst_ff;
      nxt_flags[WATCHDOG_BIT] = nxt_flags[WATCHDOG_BIT] |
                                wdt_src;
      nxt_flags[DEBUG_BIT] = nxt_flags[DEBUG_BIT] |
                             debug_reset_req_in;
      nxt_flags[SOFT_BIT] = nxt_flags[SOFT_BIT] | sw_src;
      // Request self-clears as the reset is issued
      nxt_soft_reset_request = 1'b0;
      if (wr_en_in && addr_in == CONTROL_OFS && ccp_unlock_in &&
          !soft_reset_request_ff) begin
         nxt_soft_reset_request = wr_data_in[SOFT_REQ_BIT];
      end
      // Read data stands one cycle after the strobe
      nxt_rd_data = 8'h0;
      if (rd_en_in) begin
         if (addr_in == CAUSE_FLAGS_OFS) begin
            nxt_rd_data = {2'h0, flags_ff};
         end else if (addr_in == CONTROL_OFS) begin
            nxt_rd_data = {7'h0, soft_reset_request_ff};
         end
      end
   end

   // Register file flops
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags_ff <= CAUSE_FLAGS_RST;
         soft_reset_request_ff <= CONTROL_RST;
         rd_data_ff <= 8'h0;
      end else begin
         flags_ff <= nxt_flags;
         soft_reset_request_ff <= nxt_soft_reset_request;
         rd_data_ff <= nxt_rd_data;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rd_data_out = rd_data_ff;
   assign device_reset_out = reset_ff;
   assign cpu_halt_out = soft_reset_request_ff;
   assign bod_enable_out = bod_en_ff;
   assign bod_level_out = out_level_ff;

endmodule // reset_source_controller

// ===== reset_source_pkg.sv
package reset_source_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] CAUSE_FLAGS_OFS = 4'h0; // reset_cause_flags
   localparam logic [3:0] CONTROL_OFS = 4'h1; // reset_control

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int POWER_ON_BIT = 0;
   localparam int PIN_BIT = 1;
   localparam int BROWNOUT_BIT = 2;
   localparam int WATCHDOG_BIT = 3;
   localparam int DEBUG_BIT = 4;
   localparam int SOFT_BIT = 5;
   localparam int SOFT_REQ_BIT = 0;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [5:0] CAUSE_FLAGS_RST = 6'h01;
   localparam logic CONTROL_RST = 1'h0;

   // ----------------------------------------
   // Fuse encodings
   // ----------------------------------------
   localparam logic [1:0] MODE_RESERVED = 2'h0;
   localparam logic [1:0] MODE_SAMPLED = 2'h1;
   localparam logic [1:0] MODE_ENABLED = 2'h2;
   localparam logic [1:0] MODE_DISABLED = 2'h3;
   localparam logic [2:0] LEVEL_LOWEST = 3'h0;
   localparam logic [1:0] DELAY_64K = 2'h0;
   localparam logic [1:0] DELAY_4K = 2'h1;
   localparam logic [1:0] DELAY_SYS_ONLY = 2'h3;
   localparam logic [16:0] ULP_COUNT_64K = 17'h10000;
   localparam logic [16:0] ULP_COUNT_4K = 17'h01000;
   localparam logic [4:0] SYS_COUNT = 5'h18;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int ULP_PERIOD_NS = 1000000;
   localparam int ULP_DIV_CYC = ULP_PERIOD_NS / CLK_PERIOD_NS;
   localparam int OSC2M_PERIOD_NS = 500;
   localparam int OSC2M_DIV_CYC = OSC2M_PERIOD_NS / CLK_PERIOD_NS;
   localparam int T_BOD_NS = 1000;
   localparam int T_BOD_CYC = (T_BOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_EXT_NS = 1000;
   localparam int T_EXT_CYC = (T_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------
   // Fuse bundle
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] brownout_threshold_select;
      logic [1:0] brownout_active_mode_select;
      logic [1:0] brownout_sleep_mode_select;
      logic [1:0] startup_delay_code;
   } fuse_s;

endpackage

// ===== reset_source_monitor.sv
module reset_source_monitor #(
   parameter int ULP_DIV = reset_source_pkg::ULP_DIV_CYC
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [7:0] rd_data_out,
   input wire logic ccp_unlock_in,
   input wire logic supply_below_por_in,
   input wire logic bod_below_in,
   input wire logic pin_reset_n_in,
   input wire logic watchdog_timeout_in,
   input wire logic debug_reset_req_in,
   input wire logic debug_enabled_in,
   input wire logic chip_erase_in,
   input wire logic programming_mode_in,
   input wire logic deep_sleep_in,
   input wire reset_source_pkg::fuse_s fuses_in,
   input wire logic device_reset_out,
   input wire logic cpu_halt_out,
   input wire logic bod_enable_out,
   input wire logic [2:0] bod_level_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import reset_source_pkg::*;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic [7:0] pin_low_ff; // Cycles the pin has been low
   logic [7:0] nxt_pin_low;
   logic [1:0] cur_mode; // Detector mode for present state
   logic soft_wr; // Write of the request bit
   logic no_force; // No forced-on condition
   assign cur_mode = deep_sleep_in ? fuses_in.brownout_sleep_mode_select
                                   : fuses_in.brownout_active_mode_select;
   assign soft_wr = wr_en_in && addr_in == CONTROL_OFS && wr_data_in[0];
   assign no_force = !debug_enabled_in && !chip_erase_in;
   // Saturating low-time count
   always_comb begin
      nxt_pin_low = pin_low_ff;
      if (pin_reset_n_in) nxt_pin_low = 8'h00;
      else if (pin_low_ff != 8'hff) nxt_pin_low = pin_low_ff + 8'h01;
   end
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) pin_low_ff <= 8'h00;
      else pin_low_ff <= nxt_pin_low;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   ctrl_rsvd_a: assert property (rd_en_in && addr_in == CONTROL_OFS
      |=> rd_data_out[7:1] == 7'h00) else $error("control spare bits set");
   flag_rsvd_a: assert property (rd_en_in && addr_in == CAUSE_FLAGS_OFS
      |=> rd_data_out[7:6] == 2'h0) else $error("flag spare bits set");
   soft_seq_a: assert property (soft_wr && ccp_unlock_in
      && !cpu_halt_out && !device_reset_out
      |=> cpu_halt_out ##1 (device_reset_out && !cpu_halt_out))
      else $error("soft reset sequence wrong");
   soft_lock_a: assert property (soft_wr && !ccp_unlock_in
      && !cpu_halt_out |=> !cpu_halt_out) else $error("locked write took");
   halt_once_a: assert property (cpu_halt_out |=> !cpu_halt_out)
      else $error("halt held too long");
   por_hold_a: assert property (supply_below_por_in |=> device_reset_out)
      else $error("no reset on low supply");
   dbg_hold_a: assert property (debug_reset_req_in |=> device_reset_out)
      else $error("no reset on debug request");
   pin_hold_a: assert property (pin_low_ff >= 8'h6e |-> device_reset_out)
      else $error("no reset on long pin low");
   level_map_a: assert property ((!programming_mode_in && no_force
      && $stable(fuses_in))[*4]
      |-> bod_level_out == ~fuses_in.brownout_threshold_select)
      else $error("level decode wrong");
   force_on_a: assert property ((debug_enabled_in && !deep_sleep_in
      && fuses_in.brownout_active_mode_select == MODE_DISABLED)[*3]
      |-> bod_enable_out && bod_level_out == LEVEL_LOWEST)
      else $error("detector not forced on");
   samp_pulse_a: assert property (cur_mode == MODE_SAMPLED && no_force
      && !bod_below_in && $rose(bod_enable_out) |=> !bod_enable_out)
      else $error("sample pulse too long");
   on_mode_a: assert property ((cur_mode == MODE_ENABLED)[*3]
      |-> bod_enable_out) else $error("detector off in enabled mode");
   off_mode_a: assert property ((cur_mode == MODE_DISABLED && no_force
      && !bod_below_in)[*3] |-> !bod_enable_out)
      else $error("detector on in disabled mode");
   cover property (cpu_halt_out);
   cover property ($rose(bod_enable_out) && cur_mode == MODE_SAMPLED);
   cover property (pin_low_ff == 8'h6e);
endmodule // reset_source_monitor

bind reset_source_controller reset_source_monitor #(.ULP_DIV(ULP_DIV)) mon (.*);

// ===== reset_source_partner.sv
module reset_source_partner (
   input wire logic mclk_in,
   output logic supply_below_por_out,
   output logic bod_below_out,
   output logic pin_reset_n_out,
   output logic watchdog_timeout_out,
   output logic debug_reset_req_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Supply monitors, pin and watchdog
   // ----------------------------------------
   // All sources idle; pin rests at its pull-up level
   initial begin
      {supply_below_por_out, bod_below_out} = 2'h0;
      {watchdog_timeout_out, debug_reset_req_out} = 2'h0;
      pin_reset_n_out = 1'b1;
   end
   // Set one source active or idle
   task automatic drive(input int src, input logic v);
      case (src)
         0: pin_reset_n_out <= ~v;
         1: bod_below_out <= v;
         2: watchdog_timeout_out <= v;
         3: debug_reset_req_out <= v;
         default: supply_below_por_out <= v;
      endcase
   endtask
   // Hold one source active for n cycles, launched after an edge
   task automatic fire(input int src, input int n);
      @(posedge mclk_in);
      drive(src, 1'b1);
      repeat (n) @(posedge mclk_in);
      drive(src, 1'b0);
   endtask
endmodule // reset_source_partner

// ===== tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import reset_source_pkg::*;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam int ULTRA_LOW_POWER_OSCILLATOR = 2; // Short ULTRA_LOW_POWER_OSCILLATOR tick, keeps the 4K delay short
   logic mclk_in = 1'b0;
   logic rst_n_in, wr_en_in, rd_en_in, ccp_unlock_in, debug_enabled_in;
   logic chip_erase_in, programming_mode_in, deep_sleep_in;
   logic supply_below_por_in, bod_below_in, pin_reset_n_in;
   logic watchdog_timeout_in, debug_reset_req_in;
   logic device_reset_out, cpu_halt_out, bod_enable_out;
   logic [2:0] bod_level_out;
   logic [3:0] addr_in;
   logic [7:0] wr_data_in, rd_data_out, d;
   logic [8:0] n; // Detector-on cycle count
   fuse_s fuses_in;
   int miscompares = 0, n_tests = 0, cyc = 0, s, i;
   integer seed = 32'h5290;
   reset_source_controller #(.ULP_DIV(ULTRA_LOW_POWER_OSCILLATOR)) dut (.*);
   reset_source_partner p (.mclk_in(mclk_in),
      .supply_below_por_out(supply_below_por_in),
      .bod_below_out(bod_below_in), .pin_reset_n_out(pin_reset_n_in),
      .watchdog_timeout_out(watchdog_timeout_in),
      .debug_reset_req_out(debug_reset_req_in));
   always #5 mclk_in = ~mclk_in;
   // ----------------------------------------
   // Expectations and bus tasks
   // ----------------------------------------
   function automatic logic [7:0] exp_flag(input int src);
      return (src == 4) ? 8'h01 : 8'h02 << src;
   endfunction
   function automatic logic [2:0] exp_level(input logic [2:0] c);
      return 3'h7 - c;
   endfunction
   function automatic logic [8:0] exp_on(input logic [1:0] m);
      if (m == MODE_ENABLED) return 9'(10 * ULTRA_LOW_POWER_OSCILLATOR);
      return (m == MODE_SAMPLED) ? 9'h00a : 9'h000;
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic u);
      @(posedge mclk_in);
      {addr_in, wr_data_in, wr_en_in, ccp_unlock_in} <= {a, v, 1'b1, u};
      @(posedge mclk_in);
      {wr_en_in, ccp_unlock_in} <= 2'h0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_in);
      {addr_in, rd_en_in} <= {a, 1'b1};
      @(posedge mclk_in);
      rd_en_in <= 1'b0;
      #1 d = rd_data_out;
   endtask
   task automatic wait_rel();
      for (int k = 0; k < 4000 && device_reset_out !== 1'b0; k++)
         @(posedge mclk_in);
      #1 `CHK(device_reset_out, 1'b0)
   endtask
   task automatic end_test(input string t);
      $display("test %s done", t);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         complete_run();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      {rst_n_in, wr_en_in, rd_en_in, ccp_unlock_in} = 4'h0;
      {debug_enabled_in, chip_erase_in, programming_mode_in} = 3'h0;
      {deep_sleep_in, addr_in, wr_data_in} = 13'h0000;
      fuses_in = {3'h7, MODE_ENABLED, MODE_SAMPLED, DELAY_SYS_ONLY};
      repeat (16) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      #1 `CHK(device_reset_out, 1'b1)
      wait_rel();
      rd(CAUSE_FLAGS_OFS);
      `CHK(d, 8'h01)
      s = 2 + ({$random(seed)} % 14);
      rd(s[3:0]);
      `CHK(d, 8'h00)
      end_test("reset");
      wr(CONTROL_OFS, 8'h01, 1'b0);
      rd(CONTROL_OFS);
      `CHK(d, 8'h00)
      wr(CONTROL_OFS, 8'h01, 1'b1);
      #1 `CHK(cpu_halt_out, 1'b1)
      @(posedge mclk_in);
      #1 `CHK(device_reset_out, 1'b1)
      `CHK(cpu_halt_out, 1'b0)
      wait_rel();
      rd(CONTROL_OFS);
      `CHK(d, 8'h00)
      rd(CAUSE_FLAGS_OFS);
      `CHK(d, 8'h21)
      wr(CAUSE_FLAGS_OFS, 8'h20, 1'b0);
      rd(CAUSE_FLAGS_OFS);
      `CHK(d, 8'h01)
      wr(CAUSE_FLAGS_OFS, 8'h01, 1'b0);
      rd(CAUSE_FLAGS_OFS);
      `CHK(d, 8'h00)
      p.fire(0, 10 + ({$random(seed)} % 80));
      rd(CAUSE_FLAGS_OFS);
      `CHK(d, 8'h00)
      end_test("soft and flags");
      // Pin, brownout, watchdog, debug, then power-on over a debug flag
      for (s = 0; s < 5; s++) begin
         p.fire(s, s == 0 ? 150 + ({$random(seed)} % 50) : s == 2 ? 1 : 150);
         repeat (20) @(posedge mclk_in);
         #1 `CHK(device_reset_out, 1'b1)
         wait_rel();
         rd(CAUSE_FLAGS_OFS);
         `CHK(d, exp_flag(s))
         if (s != 3) wr(CAUSE_FLAGS_OFS, 8'h3f, 1'b0);
      end
      end_test("sources");
      // Long release delay: 4K slow ticks, then the system clocks
      @(posedge mclk_in) fuses_in.startup_delay_code <= DELAY_4K;
      p.fire(3, 5);
      repeat (4096 * ULTRA_LOW_POWER_OSCILLATOR) @(posedge mclk_in);
      #1 `CHK(device_reset_out, 1'b1)
      wait_rel();
      rd(CAUSE_FLAGS_OFS);
      `CHK(d, exp_flag(3))
      end_test("delay");
      for (i = 0; i < 8; i++) begin
         fuses_in.brownout_threshold_select <= i[2:0];
         repeat (5) @(posedge mclk_in);
         `CHK(bod_level_out, exp_level(i[2:0]))
      end
      programming_mode_in <= 1'b1;
      fuses_in.brownout_threshold_select <= 3'h2;
      repeat (5) @(posedge mclk_in);
      `CHK(bod_level_out, exp_level(3'h7))
      programming_mode_in <= 1'b0;
      repeat (5) @(posedge mclk_in);
      `CHK(bod_level_out, exp_level(3'h2))
      end_test("levels");
      deep_sleep_in <= 1'b1;
      fuses_in.brownout_active_mode_select <= MODE_DISABLED;
      for (i = 3; i > 0; i--) begin
         fuses_in.brownout_sleep_mode_select <= i[1:0];
         repeat (5) @(posedge mclk_in);
         n = 9'h000;
         repeat (10 * ULTRA_LOW_POWER_OSCILLATOR) begin
            @(posedge mclk_in);
            #1 n = n + {8'h00, bod_enable_out};
         end
         `CHK(n, exp_on(i[1:0]))
      end
      deep_sleep_in <= 1'b0;
      debug_enabled_in <= 1'b1;
      repeat (5) @(posedge mclk_in);
      `CHK(bod_enable_out, 1'b1)
      `CHK(bod_level_out, LEVEL_LOWEST)
      {debug_enabled_in, chip_erase_in} <= 2'h1;
      repeat (5) @(posedge mclk_in);
      `CHK(bod_enable_out, 1'b1)
      end_test("modes");
      complete_run();
   end
endmodule // tb
